// ### inc/ir_carrier_regs.svh
// register map, field positions and timing figures of the carrier block
`ifndef IR_CARRIER_REGS_SVH
`define IR_CARRIER_REGS_SVH

// register byte addresses
`define IRC_CTRL_ADDR 8'h00
`define IRC_TLOAD_ADDR 8'h04
`define IRC_TCOUNT_ADDR 8'h08
`define IRC_STATUS_ADDR 8'h0C
`define IRC_ADDR_MSB 7

// control register fields
`define IRC_CTRL_EN_BIT 0
`define IRC_CTRL_SEL_LSB 1
`define IRC_CTRL_SEL_MSB 2
`define IRC_CTRL_RUN_BIT 3
`define IRC_CTRL_HALT_BIT 4
`define IRC_CTRL_RESET 5'h00

// status register fields
`define IRC_ST_HALTED_BIT 0
`define IRC_ST_CARRIER_BIT 1
`define IRC_ST_MODE_BIT 2

// clock rates in kHz
`define IRC_CLK_KHZ 15'h4E20
`define IRC_OSC_KHZ 15'h01C7
`define IRC_PHASE_W 15

// fixed carrier frequencies in kHz, period rounded to nearest tick
`define IRC_F38_KHZ 15'h0026
`define IRC_F57_KHZ 15'h0039
`define IRC_PERIOD(f) ((`IRC_OSC_KHZ + (f) / 15'h0002) / (f))

// free-running halt release interval
`define IRC_HALT_MS 16'h006C
`define IRC_HALT_TICKS (`IRC_HALT_MS * 16'h01C7)

// low byte value at which the timer low half overflows
`define IRC_LOW_MAX 8'hFF

`endif

// ### inc/ir_carrier_pkg.sv
// types shared by the carrier generator and its timer
package ir_carrier_pkg;

    // fixed carrier settings, reset value first
    typedef enum logic [1:0] {
        CARRIER_38K_THIRD = 2'h0,
        CARRIER_38K_HALF = 2'h1,
        CARRIER_57K_HALF = 2'h2
    } carrier_sel_e;

    // controller execution state, gray coded
    typedef enum logic [1:0] {
        CPU_RUN = 2'h0,
        CPU_HALT = 2'h1
    } cpu_state_e;

    // software control fields
    typedef struct packed {
        logic halt_enter;
        logic timer_run;
        carrier_sel_e sel;
        logic carrier_en;
    } ctrl_s;

    // timer load request
    typedef struct packed {
        logic load;
        logic [15:0] value;
    } timer_load_s;

endpackage

// ### verilog/ir_timer16.sv
// 16-bit general timer counting ceramic oscillator ticks
`timescale 1ns/100ps
`include "ir_carrier_regs.svh"

module ir_timer16
    import ir_carrier_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic osc_tick,
    input wire logic run,
    input wire timer_load_s load_req,
    output logic [15:0] count,
    output logic low_ovf
);

    logic [7:0] reload_low;

    // reload value for the low half
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            reload_low <= 8'h00;
        else if (load_req.load)
            reload_low <= load_req.value[7:0];
    end

    // counter: low half reloads on overflow, high half counts overflows
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            count <= 16'h0000;
        else if (load_req.load)
            count <= load_req.value;
        else if (run && osc_tick)
        begin
            if (count[7:0] == `IRC_LOW_MAX)
            begin
                count[7:0] <= reload_low; // RULE4
                count[15:8] <= count[15:8] + 8'h01; // RULE7
            end
            else
                count[7:0] <= count[7:0] + 8'h01; // RULE7
        end
    end

    // one-cycle overflow strobe of the low byte
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            low_ovf <= 1'b0;
        else
            low_ovf <= run && osc_tick && (count[7:0] == `IRC_LOW_MAX);
    end

endmodule

// ### verilog/ir_carrier_generator.sv
// infrared carrier generator with general timer and halt control
//
// Functional notes
// RULE1: software switches the carrier on the output pin on and off.
// RULE2: fixed mode offers 38 kHz 1/3, 38 kHz 1/2 and 57 kHz 1/2 duty.
// RULE3: fixed or timer carrier source is a build-time parameter.
// RULE4: timer mode builds the carrier from the timer low byte overflow.
// RULE5: timer mode spans 1 kHz to 200 kHz at a 455 kHz oscillator.
// RULE6: reset drives the pin low and selects 38 kHz at 1/3 duty.
// RULE7: the general timer is 16 bits, software run, clocked at 455 kHz.
// RULE8: a free-running timer requests halt release every 108 ms.
// RULE9: in halt the controller stops while oscillator and timers run.
// RULE10: halt is left only on reset or on the periodic release request.
// RULE11: while the carrier is disabled the pin is held low.
`timescale 1ns/100ps
`include "ir_carrier_regs.svh"

module ir_carrier_generator
    import ir_carrier_pkg::*;
#(
    parameter bit TIMER_CARRIER = 1'b0,
    parameter logic [15:0] HALT_RELEASE_TICKS = `IRC_HALT_TICKS
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic carrier_out_pin,
    output logic halt_release,
    output logic cpu_halted
);

    localparam logic [3:0] P38 = 4'(`IRC_PERIOD(`IRC_F38_KHZ));
    localparam logic [3:0] P57 = 4'(`IRC_PERIOD(`IRC_F57_KHZ));

    ctrl_s ctrl;
    timer_load_s tload;
    cpu_state_e state;
    cpu_state_e next_state;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic acc_req;
    logic [`IRC_PHASE_W-1:0] phase;
    logic [`IRC_PHASE_W:0] next_phase;
    logic osc_tick;
    logic [15:0] tcount;
    logic low_ovf;
    logic [3:0] fix_cnt;
    logic [3:0] fix_period;
    logic [3:0] fix_high;
    logic tmr_wave;
    logic source;
    logic [15:0] halt_cnt;
    logic halt_wrap;
    logic [31:0] rd_mux;
    logic seen_ctrl_write;

    // address phase accepted when selected, nonseq or seq, bus ready
    assign acc_req = hsel && htrans[1] && hready;

    // write address held over into the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end
        else
        begin
            wr_pend <= acc_req && hwrite;
            if (acc_req)
                wr_addr <= haddr[`IRC_ADDR_MSB:0];
        end
    end

    // control register; the halt entry bit is a one-cycle strobe
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl <= ctrl_s'(`IRC_CTRL_RESET); // RULE6
        else if (wr_pend && wr_addr == `IRC_CTRL_ADDR)
        begin
            ctrl.carrier_en <= hwdata[`IRC_CTRL_EN_BIT]; // RULE1
            ctrl.sel <= carrier_sel_e'(
                hwdata[`IRC_CTRL_SEL_MSB:`IRC_CTRL_SEL_LSB]); // RULE2
            ctrl.timer_run <= hwdata[`IRC_CTRL_RUN_BIT]; // RULE7
            ctrl.halt_enter <= hwdata[`IRC_CTRL_HALT_BIT];
        end
        else
            ctrl.halt_enter <= 1'b0;
    end

    // timer load strobe
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tload <= '0;
        else
        begin
            tload.load <= wr_pend && wr_addr == `IRC_TLOAD_ADDR;
            tload.value <= hwdata[15:0];
        end
    end

    // read data, registered for the data phase
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (haddr[`IRC_ADDR_MSB:0])
            `IRC_CTRL_ADDR:
                rd_mux = {28'h000_0000, ctrl.timer_run, ctrl.sel,
                    ctrl.carrier_en};
            `IRC_TCOUNT_ADDR:
                rd_mux = {16'h0000, tcount};
            `IRC_STATUS_ADDR:
            begin
                rd_mux[`IRC_ST_HALTED_BIT] = cpu_halted;
                rd_mux[`IRC_ST_CARRIER_BIT] = carrier_out_pin;
                rd_mux[`IRC_ST_MODE_BIT] = TIMER_CARRIER;
            end
            default:
                rd_mux = 32'h0000_0000;
        endcase
    end

    // read data, zero wait states and always an okay response
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (acc_req && !hwrite)
                hrdata <= rd_mux;
        end
    end

    // 455 kHz oscillator tick from the bus clock by phase accumulation
    assign next_phase = {1'b0, phase} + {1'b0, `IRC_OSC_KHZ};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase <= 15'h0000;
            osc_tick <= 1'b0;
        end
        else if (next_phase >= {1'b0, `IRC_CLK_KHZ})
        begin
            phase <= `IRC_PHASE_W'(next_phase - {1'b0, `IRC_CLK_KHZ});
            osc_tick <= 1'b1; // RULE7
        end
        else
        begin
            phase <= next_phase[`IRC_PHASE_W-1:0];
            osc_tick <= 1'b0;
        end
    end

    // general timer keeps running in halt
    ir_timer16 u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .osc_tick(osc_tick),
        .run(ctrl.timer_run), // RULE9
        .load_req(tload),
        .count(tcount),
        .low_ovf(low_ovf)
    );

    // fixed carrier period and high time per setting
    always_comb
    begin
        case (ctrl.sel)
            CARRIER_38K_THIRD:
            begin
                fix_period = P38;
                fix_high = 4'(P38 / 4'h3); // RULE2
            end
            CARRIER_38K_HALF:
            begin
                fix_period = P38;
                fix_high = 4'(P38 / 4'h2); // RULE2
            end
            CARRIER_57K_HALF:
            begin
                fix_period = P57;
                fix_high = 4'(P57 / 4'h2); // RULE2
            end
            default:
            begin
                fix_period = P38;
                fix_high = 4'(P38 / 4'h3);
            end
        endcase
    end

    // fixed carrier divider restarts while disabled
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            fix_cnt <= 4'h0;
        else if (!ctrl.carrier_en)
            fix_cnt <= 4'h0;
        else if (osc_tick)
            fix_cnt <= (fix_cnt >= fix_period - 4'h1) ? 4'h0
                : fix_cnt + 4'h1;
    end

    // timer carrier: each low byte overflow flips the wave
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tmr_wave <= 1'b0;
        else if (!ctrl.carrier_en)
            tmr_wave <= 1'b0;
        else if (low_ovf)
            tmr_wave <= !tmr_wave; // RULE4 RULE5
    end

    // source picked at build time
    assign source = TIMER_CARRIER ? tmr_wave // RULE3
        : (fix_cnt < fix_high);

    // carrier pin, low at reset and while disabled
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            carrier_out_pin <= 1'b0; // RULE6
        else
            carrier_out_pin <= ctrl.carrier_en && source; // RULE1 RULE11
    end

    // free-running halt release timer, no software control
    assign halt_wrap = osc_tick && halt_cnt == HALT_RELEASE_TICKS - 16'h0001;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            halt_cnt <= 16'h0000;
        else if (halt_wrap)
            halt_cnt <= 16'h0000; // RULE8
        else if (osc_tick)
            halt_cnt <= halt_cnt + 16'h0001; // RULE8 RULE9
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            halt_release <= 1'b0;
        else
            halt_release <= halt_wrap; // RULE8
    end

    // execution state: halt left only by the release request or reset
    always_comb
    begin
        case (state)
            CPU_RUN:
                next_state = ctrl.halt_enter ? CPU_HALT : CPU_RUN;
            CPU_HALT:
                next_state = halt_release ? CPU_RUN : CPU_HALT; // RULE10
            default:
                next_state = CPU_RUN;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state <= CPU_RUN;
        else
            state <= next_state;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cpu_halted <= 1'b0;
        else
            cpu_halted <= (next_state == CPU_HALT); // RULE9
    end

    // helper: any control write since reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            seen_ctrl_write <= 1'b0;
        else if (wr_pend && wr_addr == `IRC_CTRL_ADDR)
            seen_ctrl_write <= 1'b1;
    end

    // checks
    AST_CARRIER_OFF_LOW: assert property ( // RULE11
        @(posedge hclk) disable iff (!hresetn)
        !ctrl.carrier_en |=> !carrier_out_pin)
        else $error("carrier pin high while disabled");
    AST_ENABLE_FOLLOWS_SOURCE: assert property ( // RULE1
        @(posedge hclk) disable iff (!hresetn)
        ctrl.carrier_en |=> carrier_out_pin == $past(source))
        else $error("carrier pin does not follow source");
    AST_DEFAULT_SETTING: assert property ( // RULE6
        @(posedge hclk) disable iff (!hresetn)
        !seen_ctrl_write |-> ctrl.sel == CARRIER_38K_THIRD
            && !carrier_out_pin)
        else $error("reset carrier setting wrong");
    AST_FIXED_DUTY: assert property ( // RULE2
        @(posedge hclk) disable iff (!hresetn)
        ctrl.sel == CARRIER_57K_HALF |-> fix_high == 4'h4
            && fix_period == 4'h8)
        else $error("57 kHz divider wrong");
    AST_FIXED_38_PERIOD: assert property ( // RULE2
        @(posedge hclk) disable iff (!hresetn)
        ctrl.sel != CARRIER_57K_HALF |-> fix_period == 4'hC
            && fix_cnt < 4'hC)
        else $error("38 kHz divider wrong");
    AST_TIMER_TOGGLE: assert property ( // RULE4
        @(posedge hclk) disable iff (!hresetn)
        low_ovf && ctrl.carrier_en |=> tmr_wave != $past(tmr_wave))
        else $error("timer overflow did not flip carrier");
    AST_OSC_SPACING: assert property ( // RULE7
        @(posedge hclk) disable iff (!hresetn)
        osc_tick |=> (!osc_tick) [*8])
        else $error("oscillator ticks too close");
    AST_HALT_IN_RANGE: assert property ( // RULE8
        @(posedge hclk) disable iff (!hresetn)
        halt_release |-> halt_cnt == 16'h0000)
        else $error("halt release off its interval");
    AST_HALT_HOLDS: assert property ( // RULE10
        @(posedge hclk) disable iff (!hresetn)
        state == CPU_HALT && !halt_release |=> state == CPU_HALT)
        else $error("halt left without release");
    AST_HALT_WAKE: assert property ( // RULE10
        @(posedge hclk) disable iff (!hresetn)
        state == CPU_HALT && halt_release |=> state == CPU_RUN ##1
            !cpu_halted)
        else $error("release did not end halt");
    AST_TIMERS_RUN_HALTED: assert property ( // RULE9
        @(posedge hclk) disable iff (!hresetn)
        cpu_halted && osc_tick && !halt_wrap |=>
            halt_cnt == $past(halt_cnt) + 16'h0001)
        else $error("free-running timer stopped in halt");
    COV_CARRIER_RISE: cover property (
        @(posedge hclk) disable iff (!hresetn) $rose(carrier_out_pin));
    COV_HALT_ENTER: cover property (
        @(posedge hclk) disable iff (!hresetn) $rose(cpu_halted));
    COV_HALT_WAKE: cover property (
        @(posedge hclk) disable iff (!hresetn)
        cpu_halted && halt_release);
    COV_TIMER_OVF: cover property (
        @(posedge hclk) disable iff (!hresetn) low_ovf);

endmodule

// ### verification/ir_emitter_model.sv
// infrared emitter model timing the carrier pulses it receives
`timescale 1ns/100ps

module ir_emitter_model
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic drive,
    output logic [15:0] hi_len,
    output logic [15:0] per_len,
    output logic [7:0] rises
);
    logic [15:0] run_cnt;
    logic [15:0] hi_cnt;
    logic last;

    // time each lit phase and each rise-to-rise period
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hi_len <= 16'h0000;
            per_len <= 16'h0000;
            rises <= 8'h00;
            run_cnt <= 16'h0000;
            hi_cnt <= 16'h0000;
            last <= 1'b0;
        end
        else
        begin
            last <= drive;
            run_cnt <= (drive && !last) ? 16'h0001 : run_cnt + 16'h0001;
            hi_cnt <= drive ? hi_cnt + 16'h0001 : 16'h0000;
            if (drive && !last)
            begin
                per_len <= run_cnt;
                rises <= rises + 8'h01;
            end
            if (!drive && last)
                hi_len <= hi_cnt;
        end
    end
endmodule

// ### verification/test_ir_carrier_generator.sv
// bench for the carrier generator in fixed and timer source builds
`timescale 1ns/100ps
`include "ir_carrier_regs.svh"

module test_ir_carrier_generator;
    logic hclk, hresetn, hsel_a, hsel_b, hwrite, tgt;
    logic [31:0] haddr, hwdata, rd_a, rd_b, hrdata, t;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hready, rdy_a, rdy_b, pin_a, pin_b, emit, halt_rel, halted;
    logic resp_a, resp_b, resp;
    logic [15:0] hi_len, per_len;
    logic [7:0] rises;
    logic [7:0] rl [2];
    int err_total, n_checks, cycles, n;

    assign hready = tgt ? rdy_b : rdy_a;
    assign hrdata = tgt ? rd_b : rd_a;
    assign emit = tgt ? pin_b : pin_a;
    assign resp = tgt ? resp_b : resp_a;

    // fixed source build on select a
    ir_carrier_generator #(.TIMER_CARRIER(1'b0), .HALT_RELEASE_TICKS(16))
    ir_carrier_generator_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel_a), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(rdy_a), .hresp(resp_a), .hrdata(rd_a),
        .carrier_out_pin(pin_a), .halt_release(halt_rel),
        .cpu_halted(halted));

    // timer source build on select b
    ir_carrier_generator #(.TIMER_CARRIER(1'b1), .HALT_RELEASE_TICKS(16))
    ir_carrier_generator_inst2 (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel_b), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(rdy_b), .hresp(resp_b), .hrdata(rd_b),
        .carrier_out_pin(pin_b), .halt_release(), .cpu_halted());

    ir_emitter_model ir_emitter_model_inst (.hclk(hclk),
        .hresetn(hresetn), .drive(emit), .hi_len(hi_len),
        .per_len(per_len), .rises(rises));

    always #25 hclk = ~hclk;

    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // hang guard
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_total++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_rng(input logic [31:0] got, input int lo,
        input int hi);
        n_checks++;
        if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1))
        begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask

    // one single word transfer, address phase then data phase
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        hsel_a <= !tgt;
        hsel_b <= tgt;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        check(x, e);
        // every checked read must end with an okay response
        check(32'(resp), 32'h0);
    endtask

    // lit and period lengths in osc ticks, skipping two settling periods
    task automatic measure(input int ht, input int pt);
        logic [7:0] s;
        s = rises;
        while (8'(rises - s) < 8'h03) @(posedge hclk);
        check_rng(32'(hi_len), ht * 20000 / 455 - 1, ht * 20000 / 455 + 2);
        check_rng(32'(per_len), pt * 20000 / 455 - 1, pt * 20000 / 455 + 2);
    endtask

    // main sequence
    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel_a = 1'b0;
        hsel_b = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        tgt = 1'b0;
        rl = '{8'hFF, 8'hF0};
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check(32'(pin_a), 32'h0);
        check(32'(pin_b), 32'h0);
        check(32'(halted), 32'h0);
        rd_chk(`IRC_CTRL_ADDR, 32'h0000_0000);
        rd_chk(`IRC_STATUS_ADDR, 32'h0000_0000);
        rd_chk(`IRC_TCOUNT_ADDR, 32'h0000_0000);
        wr(8'h10, 32'hFFFF_FFFF);
        rd_chk(8'h10, 32'h0000_0000);
        rd_chk(`IRC_CTRL_ADDR, 32'h0000_0000);
        // default setting after reset, then every other setting
        wr(`IRC_CTRL_ADDR, 32'h0000_0001);
        measure(4, 12);
        wr(`IRC_CTRL_ADDR, 32'h0000_0003);
        measure(6, 12);
        wr(`IRC_CTRL_ADDR, 32'h0000_0005);
        measure(4, 8);
        wr(`IRC_CTRL_ADDR, 32'h0000_0007);
        measure(4, 12);
        rd_chk(`IRC_CTRL_ADDR, 32'h0000_0007);
        // disable mid-carrier, pin held low
        wr(`IRC_CTRL_ADDR, 32'h0000_0000);
        repeat (2) @(posedge hclk);
        for (n = 0; n < 600; n++)
        begin
            if (pin_a !== 1'b0)
                check(32'(pin_a), 32'h0);
            @(posedge hclk);
        end
        check(32'(pin_a), 32'h0);
        // timer load while stopped, then count at the osc rate
        wr(`IRC_TLOAD_ADDR, 32'h0000_1234);
        // the load strobe is registered, the count lands one edge later
        @(posedge hclk);
        rd_chk(`IRC_TCOUNT_ADDR, 32'h0000_1234);
        wr(`IRC_CTRL_ADDR, 32'h0000_0008);
        repeat (440) @(posedge hclk);
        bus(1'b0, `IRC_TCOUNT_ADDR, 32'h0000_0000, t);
        check_rng(t, 32'h1234 + 9, 32'h1234 + 11);
        // halt entry, hold until release request, then release period
        wr(`IRC_CTRL_ADDR, 32'h0000_0018);
        repeat (3) @(posedge hclk);
        check(32'(halted), 32'h1);
        rd_chk(`IRC_CTRL_ADDR, 32'h0000_0008);
        n = 0;
        while (halt_rel !== 1'b1 && n < 900)
        begin
            @(posedge hclk);
            n++;
        end
        check(32'(halted), 32'h1);
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
            if (n == 1)
                check(32'(halt_rel), 32'h0);
            if (n == 3)
                check(32'(halted), 32'h0);
        end
        while (halt_rel !== 1'b1 && n < 900);
        check_rng(n, 16 * 20000 / 455 - 1, 16 * 20000 / 455 + 2);
        // timer source build: overflow driven carrier at two reloads
        tgt <= 1'b1;
        @(posedge hclk);
        rd_chk(`IRC_STATUS_ADDR, 32'h0000_0004);
        for (int i = 0; i < 2; i++)
        begin
            wr(`IRC_TLOAD_ADDR, {24'h00_0000, rl[i]});
            wr(`IRC_CTRL_ADDR, 32'h0000_0009);
            measure(256 - rl[i], 2 * (256 - rl[i]));
        end
        wr(`IRC_CTRL_ADDR, 32'h0000_0000);
        repeat (2) @(posedge hclk);
        check(32'(pin_b), 32'h0);
        end_of_test();
    end
endmodule
